// >>> hw/ebac_ctrl.sv
// Byte access controller for the on-chip data array, top level.
`timescale 1ns/10ps
// What this block does
// [RL1] High address bits 15:12 and control bits 7:6 read zero, cannot change.
// [RL2] Low and high address registers form a 12-bit byte address.
// [RL3] Data register feeds programming and receives bytes read.
// [RL4] Mode 00 erase+program 3.4ms; 01 erase, 10 program, 1.8ms.
// [RL5] Mode field writes ignored while the programming strobe is set.
// [RL6] Reset clears mode field unless programming is still running.
// [RL7] Ready interrupt held while enabled, globally enabled and not busy.
// [RL8] Master write enable clears itself four cycles after being set.
// [RL9] Strobe set within the enable window starts programming.
// [RL10] Strobe set without master enable starts nothing.
// [RL11] Strobe reads busy during programming and clears at the end.
// [RL12] Launching programming stalls the CPU two cycles.
// [RL13] Read strobe loads data at once and stalls the CPU four cycles.
// [RL14] While busy, reads are refused and address writes blocked.
// [RL15] No programming starts while flash self-programming is busy.
// [RL16] Programming timed by counting calibrated RC oscillator cycles.
// [RL17] Software waits, loads, sets enable, then strobe within four cycles.
// [RL18] Software should keep interrupts off during an access sequence.
// [RL19] A reset during programming lets the operation complete.
// [RL20] Reserved mode 11 performs no erase or program action.
module ebac_ctrl
	import ebac_pkg::*;
#(
	parameter int OSC_CYCLES_ATOMIC_P = OSC_CYCLES_ATOMIC,
	parameter int OSC_CYCLES_SPLIT_P  = OSC_CYCLES_SPLIT
)
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 por,
	input  wire logic [IO_ADDR_W-1:0] io_addr,
	input  wire logic [7:0]           io_wdata,
	input  wire logic                 io_we,
	input  wire logic                 io_re,
	output logic      [7:0]           io_rdata,
	input  wire logic                 global_irq_enable,
	input  wire logic                 flash_selfprog_busy,
	input  wire logic                 rc_osc,
	output logic                      cpu_stall,
	output logic                      ready_irq,
	output logic                      nvm_busy
);

	localparam logic [TIMER_W-1:0] LIMIT_ATOMIC = TIMER_W'(OSC_CYCLES_ATOMIC_P);
	localparam logic [TIMER_W-1:0] LIMIT_SPLIT  = TIMER_W'(OSC_CYCLES_SPLIT_P);

	// Software-visible registers and the master enable window counter.
	logic [7:0]             nvm_address_low_reg;
	logic [ADDR_HIGH_W-1:0] nvm_address_high_reg;
	logic [7:0]             nvm_data_byte_reg;
	logic [1:0]             prog_mode_field_reg;
	logic                   ready_irq_enable_reg;
	logic                   master_write_enable_reg;
	logic [2:0]             master_we_count_reg;

	// Operation latched at launch, kept through a system reset.
	logic [NV_ADDR_W-1:0]   op_addr_reg;
	logic [7:0]             op_data_reg;
	logic [1:0]             op_mode_reg;

	// CPU stall bookkeeping.
	logic [2:0]             stall_count_reg;

	// Programming engine phase, kept through a system reset.
	typedef enum logic [1:0] {
		ENG_IDLE,
		ENG_TIMING
	} ebac_engine_e;

	ebac_engine_e           engine_reg;
	ebac_engine_e           engine_next;

	// Decode and engine wiring.
	logic                   wr_control;
	logic                   wr_data;
	logic                   wr_addr_low;
	logic                   wr_addr_high;
	logic                   program_strobe;
	logic                   launch;
	logic                   read_go;
	logic                   prog_done;
	logic [NV_ADDR_W-1:0]   nvm_address;
	logic [7:0]             array_rd_data;
	logic [TIMER_W-1:0]     op_limit;
	logic [7:0]             control_view;

	function automatic logic io_hit(input logic [IO_ADDR_W-1:0] a,
	                                input logic [IO_ADDR_W-1:0] ofs);
		io_hit = (a == ofs);
	endfunction

	function automatic logic [TIMER_W-1:0] mode_limit(input logic [1:0] mode);
		if (mode == MODE_ATOMIC) begin
			mode_limit = LIMIT_ATOMIC;
		end else begin
			mode_limit = LIMIT_SPLIT;
		end
	endfunction

	assign wr_control   = io_we & io_hit(io_addr, OFS_CONTROL);
	assign wr_data      = io_we & io_hit(io_addr, OFS_DATA);
	assign wr_addr_low  = io_we & io_hit(io_addr, OFS_ADDR_LOW);
	assign wr_addr_high = io_we & io_hit(io_addr, OFS_ADDR_HIGH);

	// [RL2] Linear byte address.
	assign nvm_address = {nvm_address_high_reg, nvm_address_low_reg};

	// [RL9] Guarded strobe start.
	// [RL10] Needs master enable.
	// [RL15] Flash interlock gates it.
	// The enable must already stand from an earlier write; one write carrying
	// both bits is not enough, which keeps a stray store from programming.
	assign launch = wr_control & io_wdata[BIT_PROG_STROBE] & master_write_enable_reg
	              & ~program_strobe & ~flash_selfprog_busy;

	// [RL14] Reads refused while busy.
	assign read_go = wr_control & io_wdata[BIT_READ_STROBE] & ~program_strobe;

	assign op_limit = mode_limit(prog_mode_field_reg);

	// [RL1] Reserved bits read zero.
	// [RL11] Strobe reads as busy.
	// The read strobe acts within the write and never reads back set.
	assign control_view = {2'b00, prog_mode_field_reg, ready_irq_enable_reg,
	                       master_write_enable_reg, program_strobe, 1'b0};

	ebac_prog_timer u_timer (
		.clk   (clk),
		.por   (por),
		.rc_osc(rc_osc),
		.start (launch),
		.limit (op_limit),
		.busy  (),
		.done  (prog_done)
	);

	// [RL11] Busy until commit.
	// The timer finishes one edge before the cell is written, so the engine keeps
	// the strobe set until that edge; a read at once after it sees the new byte.
	always_comb begin
		engine_next = engine_reg;
		case (engine_reg)
			ENG_IDLE: begin
				if (launch) begin
					engine_next = ENG_TIMING;
				end
			end
			ENG_TIMING: begin
				if (prog_done) begin
					engine_next = ENG_IDLE;
				end
			end
			default: begin
				engine_next = ENG_IDLE;
			end
		endcase
	end

	// [RL19] Engine survives reset.
	always_ff @(posedge clk or posedge por) begin
		if (por) begin
			engine_reg <= ENG_IDLE;
		end else begin
			engine_reg <= engine_next;
		end
	end

	assign program_strobe = (engine_reg == ENG_TIMING);

	// [RL4] Action applied at time-out.
	ebac_nv_array u_array (
		.clk    (clk),
		.rd_addr(nvm_address),
		.rd_data(array_rd_data),
		.wr_en  (prog_done),
		.wr_addr(op_addr_reg),
		.wr_mode(op_mode_reg),
		.wr_data(op_data_reg)
	);

	// [RL14] Address frozen while busy.
	// [RL1] Upper high bits not stored.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nvm_address_low_reg  <= 8'h00;
			nvm_address_high_reg <= '0;
		end else if (!program_strobe) begin
			if (wr_addr_low) begin
				nvm_address_low_reg <= io_wdata;
			end
			if (wr_addr_high) begin
				nvm_address_high_reg <= io_wdata[ADDR_HIGH_W-1:0];
			end
		end
	end

	// [RL3] Data byte register.
	// [RL13] Read loads at once.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nvm_data_byte_reg <= DATA_RESET;
		end else if (read_go) begin
			nvm_data_byte_reg <= array_rd_data;
		end else if (wr_data) begin
			nvm_data_byte_reg <= io_wdata;
		end
	end

	// [RL6] Mode reset unless busy.
	// [RL5] Mode locked while busy.
	// Only power-on clears this asynchronously; a system reset clears it on
	// the clock, and only when no programming is under way.
	always_ff @(posedge clk or posedge por) begin
		if (por) begin
			prog_mode_field_reg <= MODE_ATOMIC;
		end else if (rst) begin
			if (!program_strobe) begin
				prog_mode_field_reg <= MODE_ATOMIC;
			end
		end else if (wr_control && !program_strobe) begin
			prog_mode_field_reg <= io_wdata[BIT_MODE_HI:BIT_MODE_LO];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ready_irq_enable_reg <= 1'b0;
		end else if (wr_control) begin
			ready_irq_enable_reg <= io_wdata[BIT_READY_IE];
		end
	end

	// [RL8] Master enable self-clear.
	// A launch consumes the enable so a second strobe needs a new guard write.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			master_write_enable_reg <= 1'b0;
			master_we_count_reg     <= 3'h0;
		end else if (launch) begin
			master_write_enable_reg <= 1'b0;
			master_we_count_reg     <= 3'h0;
		end else if (wr_control && io_wdata[BIT_MASTER_WE]) begin
			master_write_enable_reg <= 1'b1;
			master_we_count_reg     <= MASTER_WE_CYCLES;
		end else if (master_we_count_reg != 3'h0) begin
			master_we_count_reg <= master_we_count_reg - 3'h1;
			if (master_we_count_reg == 3'h1) begin
				master_write_enable_reg <= 1'b0;
			end
		end else begin
			master_write_enable_reg <= 1'b0;
		end
	end

	// [RL19] Operation survives reset.
	always_ff @(posedge clk or posedge por) begin
		if (por) begin
			op_addr_reg <= '0;
			op_data_reg <= DATA_RESET;
			op_mode_reg <= MODE_ATOMIC;
		end else if (launch) begin
			op_addr_reg <= nvm_address;
			op_data_reg <= nvm_data_byte_reg;
			op_mode_reg <= prog_mode_field_reg;
		end
	end

	// [RL12] Two-cycle write stall.
	// [RL13] Four-cycle read stall.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_stall       <= 1'b0;
			stall_count_reg <= 3'h0;
		end else if (launch) begin
			cpu_stall       <= 1'b1;
			stall_count_reg <= STALL_PROG_CYCLES - 3'h1;
		end else if (read_go) begin
			cpu_stall       <= 1'b1;
			stall_count_reg <= STALL_READ_CYCLES - 3'h1;
		end else if (stall_count_reg != 3'h0) begin
			stall_count_reg <= stall_count_reg - 3'h1;
		end else begin
			cpu_stall <= 1'b0;
		end
	end

	// [RL7] Level ready interrupt.
	// Held as a level, so software must clear the enable to silence it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ready_irq <= 1'b0;
		end else begin
			ready_irq <= ready_irq_enable_reg & global_irq_enable & ~(program_strobe | launch);
		end
	end

	// [RL11] Busy flag mirror.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nvm_busy <= 1'b0;
		end else begin
			nvm_busy <= program_strobe | launch;
		end
	end

	// [RL1] Read-back with zero padding.
	// Read data is registered, so it is valid the cycle after io_re.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			io_rdata <= 8'h00;
		end else if (io_re) begin
			case (io_addr)
				OFS_CONTROL:   io_rdata <= control_view;
				OFS_DATA:      io_rdata <= nvm_data_byte_reg;
				OFS_ADDR_LOW:  io_rdata <= nvm_address_low_reg;
				OFS_ADDR_HIGH: io_rdata <= {{(8 - ADDR_HIGH_W){1'b0}}, nvm_address_high_reg};
				default:       io_rdata <= 8'h00;
			endcase
		end
	end

endmodule

// >>> hw/ebac_pkg.sv
// Constants shared by the byte access controller and its helpers.
package ebac_pkg;

	// I/O register bus geometry and register offsets.
	localparam int         IO_ADDR_W      = 6;
	localparam logic [5:0] OFS_CONTROL    = 6'h1f;
	localparam logic [5:0] OFS_DATA       = 6'h20;
	localparam logic [5:0] OFS_ADDR_LOW   = 6'h21;
	localparam logic [5:0] OFS_ADDR_HIGH  = 6'h22;

	// Control register field positions.
	localparam int BIT_READ_STROBE  = 0;
	localparam int BIT_PROG_STROBE  = 1;
	localparam int BIT_MASTER_WE    = 2;
	localparam int BIT_READY_IE     = 3;
	localparam int BIT_MODE_LO      = 4;
	localparam int BIT_MODE_HI      = 5;

	// Array geometry; the high address register holds bits 11:8.
	localparam int         NV_ADDR_W      = 12;
	localparam int         NV_DEPTH       = 4096;
	localparam int         ADDR_HIGH_W    = 4;
	localparam logic [7:0] DATA_RESET     = 8'h00;
	localparam logic [7:0] ERASED_BYTE    = 8'hff;

	// Programming mode encodings.
	localparam logic [1:0] MODE_ATOMIC    = 2'h0;
	localparam logic [1:0] MODE_ERASE     = 2'h1;
	localparam logic [1:0] MODE_WRITE     = 2'h2;
	localparam logic [1:0] MODE_RESERVED  = 2'h3;

	// Guard window and CPU stall lengths, in clock cycles.
	localparam logic [2:0] MASTER_WE_CYCLES = 3'h4;
	localparam logic [2:0] STALL_PROG_CYCLES = 3'h2;
	localparam logic [2:0] STALL_READ_CYCLES = 3'h4;

	// Programming times as printed, and the oscillator cycle counts.
	localparam real PROG_TIME_ATOMIC_MS = 3.4;
	localparam real PROG_TIME_SPLIT_MS  = 1.8;
	localparam real PROG_TIME_TYP_MS    = 3.3;
	localparam int  OSC_CYCLES_ATOMIC   = 26368;
	localparam int  OSC_CYCLES_SPLIT    = int'(OSC_CYCLES_ATOMIC * PROG_TIME_SPLIT_MS / PROG_TIME_ATOMIC_MS);
	localparam int  TIMER_W             = 15;

endpackage

// >>> hw/ebac_prog_timer.sv
// Programming timer counting edges of the calibrated RC oscillator.
`timescale 1ns/10ps
module ebac_prog_timer
	import ebac_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               por,
	input  wire logic               rc_osc,
	input  wire logic               start,
	input  wire logic [TIMER_W-1:0] limit,
	output logic                    busy,
	output logic                    done
);

	logic               osc_meta_reg;
	logic               osc_sync_reg;
	logic               osc_prev_reg;
	logic [TIMER_W-1:0] count_reg;
	logic               tick;

	// The oscillator is another clock; it is synchronised before use.
	always_ff @(posedge clk or posedge por) begin
		if (por) begin
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
		end else begin
			osc_meta_reg <= rc_osc;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
		end
	end

	assign tick = osc_sync_reg & ~osc_prev_reg;

	// [RL16] Oscillator cycle count.
	// Only power-on stops this counter, so a system reset lets it finish.
	always_ff @(posedge clk or posedge por) begin
		if (por) begin
			busy      <= 1'b0;
			done      <= 1'b0;
			count_reg <= '0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy      <= 1'b1;
				count_reg <= limit;
			end else if (busy && tick) begin
				if (count_reg <= TIMER_W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				count_reg <= count_reg - TIMER_W'(1);
			end
		end
	end

endmodule

// >>> hw/ebac_nv_array.sv
// Byte-wide nonvolatile data array with erase, program and read.
`timescale 1ns/10ps
module ebac_nv_array
	import ebac_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic [NV_ADDR_W-1:0] rd_addr,
	output logic      [7:0]           rd_data,
	input  wire logic                 wr_en,
	input  wire logic [NV_ADDR_W-1:0] wr_addr,
	input  wire logic [1:0]           wr_mode,
	input  wire logic [7:0]           wr_data
);

	logic [7:0] cells [NV_DEPTH];

	assign rd_data = cells[rd_addr];

	// [RL4] Mode action on the cell.
	// Program alone can only clear bits, as a real cell would.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			case (wr_mode)
				MODE_ATOMIC: cells[wr_addr] <= wr_data;
				MODE_ERASE:  cells[wr_addr] <= ERASED_BYTE;
				MODE_WRITE:  cells[wr_addr] <= cells[wr_addr] & wr_data;
				// [RL20] Reserved mode inert.
				default:     cells[wr_addr] <= cells[wr_addr];
			endcase
		end
	end

endmodule

// >>> bench/ebac_ctrl_asserts.sv
// Port-level assertions for the byte access controller.
`timescale 1ns/10ps
module ebac_ctrl_asserts
	import ebac_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic [IO_ADDR_W-1:0] io_addr,
	input wire logic [7:0]           io_wdata,
	input wire logic                 io_we,
	input wire logic                 io_re,
	input wire logic [7:0]           io_rdata,
	input wire logic                 global_irq_enable,
	input wire logic                 cpu_stall,
	input wire logic                 ready_irq,
	input wire logic                 nvm_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// The busy flag lags a launch, so a read is only judged when busy and stall are both quiet.
	logic rd_go;
	assign rd_go = io_we && io_addr == OFS_CONTROL && io_wdata[0] && !io_wdata[1] && !nvm_busy && !cpu_stall;
	irq_busy_off_a:
		assert property (nvm_busy |-> !ready_irq) else $error("ready irq while busy");
	irq_gie_off_a:
		assert property (!global_irq_enable |=> !ready_irq) else $error("ready irq without global enable");
	rst_quiet_a:
		assert property (disable iff (1'h0) rst |-> io_rdata == 8'h00 && !cpu_stall && !ready_irq)
		else $error("outputs active in reset");
	rdata_hold_a:
		assert property (!io_re |=> $stable(io_rdata)) else $error("read data moved without read");
	unmapped_zero_a:
		assert property (io_re && (io_addr < OFS_CONTROL || io_addr > OFS_ADDR_HIGH) |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
	high_reserved_a:
		assert property (io_re && io_addr == OFS_ADDR_HIGH |=> io_rdata[7:4] == 4'h0) else $error("high bits set");
	ctl_reserved_a:
		assert property (io_re && io_addr == OFS_CONTROL |=> io_rdata[7:6] == 2'h0 && !io_rdata[0])
		else $error("control reserved bits set");
	read_stall_a:
		assert property (rd_go |=> cpu_stall [*4] ##1 !cpu_stall) else $error("read stall not four cycles");
	prog_stall_a:
		assert property ($rose(nvm_busy) && !$past(rst, 2) |-> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
		else $error("program stall not two cycles");
endmodule
bind ebac_ctrl ebac_ctrl_asserts u_chk (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
	.io_we(io_we), .io_re(io_re), .io_rdata(io_rdata), .global_irq_enable(global_irq_enable),
	.cpu_stall(cpu_stall), .ready_irq(ready_irq), .nvm_busy(nvm_busy));

// >>> bench/ebac_osc_model.sv
// Free-running calibrated RC oscillator beside the controller.
`timescale 1ns/10ps
module ebac_osc_model #(
	parameter int HALF_NS = 40
)
(
	output logic rc_osc
);
	initial begin
		rc_osc = 1'h0;
		forever #(HALF_NS) rc_osc = ~rc_osc;
	end
endmodule

// >>> bench/tb_ebac_ctrl.sv
// Self-checking bench for the byte access controller.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_ebac_ctrl
	import ebac_pkg::*;
;
	// Short counts keep each programming cycle to a few dozen clocks.
	localparam int ATOM  = 4;
	localparam int SPLIT = 2;
	logic                 clk = 1'h0;
	logic                 rst = 1'h1;
	logic                 por = 1'h1;
	logic [IO_ADDR_W-1:0] io_addr = '0;
	logic [7:0]           io_wdata = 8'h00;
	logic                 io_we = 1'h0;
	logic                 io_re = 1'h0;
	logic                 global_irq_enable = 1'h0;
	logic                 flash_selfprog_busy = 1'h0;
	logic [7:0]           io_rdata, rv, dv, old;
	logic                 rc_osc, cpu_stall, ready_irq, nvm_busy;
	logic [31:0]          rs = 32'h0000_001a;
	logic [11:0]          a;
	logic [1:0]           md;
	int                   err_count = 0;
	int                   checks_done = 0;
	int                   cycles = 0;
	int                   n;
	time                  t0;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			stop_test();
		end
	end
	ebac_osc_model u_osc (.rc_osc(rc_osc));
	ebac_ctrl #(.OSC_CYCLES_ATOMIC_P(ATOM), .OSC_CYCLES_SPLIT_P(SPLIT)) u_dut (.clk(clk), .rst(rst), .por(por),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
		.global_irq_enable(global_irq_enable), .flash_selfprog_busy(flash_selfprog_busy), .rc_osc(rc_osc),
		.cpu_stall(cpu_stall), .ready_irq(ready_irq), .nvm_busy(nvm_busy));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] exp_prog(input logic [1:0] m, input logic [7:0] o, input logic [7:0] d);
		case (m)
			MODE_ATOMIC: return d;
			MODE_ERASE: return ERASED_BYTE;
			MODE_WRITE: return o & d;
			default: return o;
		endcase
	endfunction
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [5:0] ad, input logic [7:0] d);
		@(posedge clk);
		io_we <= 1'h1;
		io_addr <= ad;
		io_wdata <= d;
		@(posedge clk);
		io_we <= 1'h0;
	endtask
	task automatic rd(input logic [5:0] ad, output logic [7:0] d);
		@(posedge clk);
		io_re <= 1'h1;
		io_addr <= ad;
		@(posedge clk);
		io_re <= 1'h0;
		@(posedge clk);
		d = io_rdata;
	endtask
	task automatic prog(input logic [1:0] m, input logic [7:0] d);
		wr(OFS_ADDR_HIGH, {4'h0, a[11:8]});
		wr(OFS_ADDR_LOW, a[7:0]);
		wr(OFS_DATA, d);
		wr(OFS_CONTROL, {2'h0, m, 4'hc});
		wr(OFS_CONTROL, {2'h0, m, 4'ha});
		t0 = $time;
	endtask
	task automatic fetch(output logic [7:0] d);
		wr(OFS_ADDR_HIGH, {4'h0, a[11:8]});
		wr(OFS_ADDR_LOW, a[7:0]);
		wr(OFS_CONTROL, 8'h01);
		rd(OFS_DATA, d);
	endtask
	task automatic wait_idle();
		repeat (2) @(posedge clk);
		for (int k = 0; k < 3000 && nvm_busy !== 1'h0; k++) begin
			@(posedge clk);
		end
		n = int'(($time - t0) / 10);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		por <= 1'h0;
		rd(OFS_CONTROL, rv);
		`CHK(rv, 8'h00)
		rd(OFS_DATA, rv);
		`CHK(rv, DATA_RESET)
		rd(6'h10, rv);
		`CHK(rv, 8'h00)
		rs = xs(rs);
		a = rs[11:0];
		wr(OFS_ADDR_HIGH, {4'hf, a[11:8]});
		wr(OFS_CONTROL, 8'hc0);
		rd(OFS_ADDR_HIGH, rv);
		`CHK(rv, {4'h0, a[11:8]})
		rd(OFS_CONTROL, rv);
		`CHK(rv, 8'h00)
		// A missing, late or interlocked enable must leave the array idle.
		for (int k = 0; k < 3; k++) begin
			flash_selfprog_busy <= (k == 2);
			if (k != 0) wr(OFS_CONTROL, 8'h04);
			if (k == 1) repeat (5) @(posedge clk);
			wr(OFS_CONTROL, 8'h02);
			repeat (3) @(posedge clk);
			`CHK(nvm_busy, 1'h0)
			rd(OFS_CONTROL, rv);
			`CHK(rv, 8'h00)
		end
		flash_selfprog_busy <= 1'h0;
		for (int m = 0; m < 4; m++) begin
			rs = xs(rs);
			md = m[1:0];
			dv = rs[7:0];
			// No handler runs here, so an access sequence is never interrupted.
			global_irq_enable <= rs[8];
			prog(md, dv);
			wr(OFS_CONTROL, {2'h0, ~md, 4'h9});
			wr(OFS_ADDR_LOW, ~a[7:0]);
			rd(OFS_CONTROL, rv);
			`CHK(rv, {2'h0, md, 4'ha})
			rd(OFS_DATA, rv);
			`CHK(rv, dv)
			wait_idle();
			n = n - 8 * ((md == MODE_ATOMIC) ? ATOM : SPLIT);
			`CHK(n > -8 && n < 8, 1'h1)
			`CHK(ready_irq, global_irq_enable)
			rd(OFS_ADDR_LOW, rv);
			`CHK(rv, a[7:0])
			fetch(rv);
			`CHK(rv, exp_prog(md, old, dv))
			old = exp_prog(md, old, dv);
		end
		rs = xs(rs);
		dv = rs[7:0];
		prog(MODE_WRITE, dv);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		wait_idle();
		rd(OFS_CONTROL, rv);
		`CHK(rv[5:4], MODE_WRITE)
		fetch(rv);
		`CHK(rv, old & dv)
		// A stored mode and enable must both be cleared by an idle reset.
		wr(OFS_CONTROL, 8'h38);
		@(posedge clk);
		rst <= 1'h1;
		@(posedge clk);
		rst <= 1'h0;
		rd(OFS_CONTROL, rv);
		`CHK(rv, 8'h00)
		stop_test();
	end
endmodule
